// File: hdl/pmic_regs_pkg.sv
/*
 * Shared constants and types for the shutdown-cause and step-down rail register bank.
 * Assumes an 8-bit register space reached over the two-wire management bus.
 */
package pmic_regs_pkg;

    // Register offsets on the management bus.
    localparam logic [7:0] ADDR_SUMMARY = 8'h02;
    localparam logic [7:0] ADDR_CAUSE = 8'h05;
    localparam logic [7:0] ADDR_RAIL1 = 8'h20;
    localparam logic [7:0] ADDR_RAIL2 = 8'h21;
    localparam logic [7:0] ADDR_RAIL3 = 8'h22;

    // Field positions.
    localparam int CAUSE_WIDTH = 4;
    localparam int OVERHEAT_BIT = 0;
    localparam int RAIL_FAULT_BIT = 1;
    localparam int UNDERVOLTAGE_BIT = 2;
    localparam int UNUSED_CAUSE_BIT = 3;
    localparam int SUMMARY_BIT = 3;
    localparam int PASSIVE_BIT = 0;

    // Reset values.
    localparam logic [3:0] CAUSE_RESET = 4'h0;
    localparam logic SUMMARY_RESET = 1'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Voltage step per code, in millivolts, for the two range options.
    localparam logic [4:0] STEP_FINE_MV = 5'h0A;
    localparam logic [4:0] STEP_COARSE_MV = 5'h19;

    // Control byte of one step-down controller: code in 7:1, discharge select in 0.
    typedef struct packed {
        logic [6:0] voltage_code;
        logic passive_discharge;
    } rail_ctrl_t;

endpackage

// File: hdl/sticky_flag.sv
/*
 * One hardware-set, write-one-to-clear status flag.
 * Assumes set and clear are single-cycle qualified strobes in the clk_in domain.
 */
`timescale 1ns/1ps
`default_nettype none

module sticky_flag #(
    parameter logic RESET_VALUE = 1'h0
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic srst_in,
    // Set and clear requests.
    input wire logic set_in,
    input wire logic clear_in,
    // Flag state.
    output logic flag_out
);

    // A set arriving in the clearing cycle wins, so no event is ever lost.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flag_out <= RESET_VALUE;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end

endmodule // sticky_flag

`default_nettype wire

// File: hdl/rail_ctrl_reg.sv
/*
 * One 8-bit read/write control byte of a step-down controller.
 * Assumes the reset value is the factory configuration applied at power-on.
 */
`timescale 1ns/1ps
`default_nettype none

module rail_ctrl_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic srst_in,
    // Write port.
    input wire logic write_in,
    input wire logic [7:0] data_in,
    // Stored byte.
    output pmic_regs_pkg::rail_ctrl_t value_out
);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            value_out <= RESET_VALUE;
        end else if (write_in) begin
            value_out <= data_in;
        end
    end

endmodule // rail_ctrl_reg

`default_nettype wire

// File: hdl/shutdown_cause_and_buck_voltage_regs.sv
/*
 * Shutdown-cause flags, shutdown summary flag and step-down rail control bytes,
 * reached through a two-wire management bus target with auto-incrementing pointer.
 * Assumes bus pins and shutdown event inputs are synchronous to clk_in, and that
 * the bus clock is far slower than clk_in so every bus edge spans many cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module shutdown_cause_and_buck_voltage_regs #(
    parameter logic [6:0] TARGET_ADDR = 7'h2A, // Arbitrary bus address.
    parameter logic STEP_IS_COARSE = 1'b0,
    parameter logic [7:0] RAIL1_RESET = 8'h00,
    parameter logic [7:0] RAIL2_RESET = 8'h00,
    parameter logic [6:0] RAIL3_CODE_RESET = 7'h00,
    parameter logic RAIL3_PASSIVE_RESET = 1'b0
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic srst_in,
    // Management bus pins; data is open drain.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_drive_n_out,
    // Shutdown events.
    input wire logic undervoltage_shutdown_in,
    input wire logic rail_fault_shutdown_in,
    input wire logic rail_fault_masked_in,
    input wire logic overheat_shutdown_in,
    // Status toward the rest of the device.
    output logic [3:0] shutdown_cause_out,
    output logic shutdown_summary_flag_out,
    // Rail controls.
    output pmic_regs_pkg::rail_ctrl_t rail1_control_out,
    output pmic_regs_pkg::rail_ctrl_t rail2_control_out,
    output logic rail3_passive_discharge_out,
    output logic [4:0] rail_step_mv_out
);

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } bus_state_t;

    bus_state_t state;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic is_read;
    logic master_ack;
    logic sda_low;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [3:0] cause;
    logic [3:0] cause_set;
    logic [3:0] cause_clr;
    logic summary;
    logic summary_clr;
    pmic_regs_pkg::rail_ctrl_t rail1;
    pmic_regs_pkg::rail_ctrl_t rail2;
    pmic_regs_pkg::rail_ctrl_t rail3;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus pin sampling and condition detection.

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;
    assign start_det = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_det = scl_in & scl_q & ~sda_q & sda_in;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus target state machine. Data is sampled on SCL rising and changed on falling.

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            is_read <= 1'b0;
            master_ack <= 1'b0;
            sda_low <= 1'b0;
        end else if (start_det) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_low <= 1'b0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            sda_low <= 1'b0;
        end else if (scl_rise) begin
            unique case (state)
                ST_ADDR, ST_PTR, ST_WR: begin
                    shift <= {shift[6:0], sda_in};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                ST_RD: bit_cnt <= bit_cnt + 4'h1;
                ST_RD_ACK: master_ack <= ~sda_in;
                ST_IDLE, ST_ADDR_ACK, ST_PTR_ACK, ST_WR_ACK: ;
            endcase
        end else if (scl_fall) begin
            unique case (state)
                ST_ADDR: if (bit_cnt == 4'h8) begin
                    bit_cnt <= 4'h0;
                    if (shift[7:1] == TARGET_ADDR) begin
                        is_read <= shift[0];
                        sda_low <= 1'b1;
                        state <= ST_ADDR_ACK;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    if (is_read) begin
                        tx <= rd_data;
                        sda_low <= ~rd_data[7];
                        state <= ST_RD;
                    end else begin
                        sda_low <= 1'b0;
                        state <= ST_PTR;
                    end
                end
                ST_PTR: if (bit_cnt == 4'h8) begin
                    bit_cnt <= 4'h0;
                    ptr <= shift;
                    sda_low <= 1'b1;
                    state <= ST_PTR_ACK;
                end
                ST_WR: if (bit_cnt == 4'h8) begin
                    bit_cnt <= 4'h0;
                    ptr <= ptr + 8'h01;
                    sda_low <= 1'b1;
                    state <= ST_WR_ACK;
                end
                ST_PTR_ACK, ST_WR_ACK: begin
                    sda_low <= 1'b0;
                    state <= ST_WR;
                end
                ST_RD: begin
                    if (bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        ptr <= ptr + 8'h01;
                        sda_low <= 1'b0;
                        state <= ST_RD_ACK;
                    end else begin
                        tx <= {tx[6:0], 1'b0};
                        sda_low <= ~tx[6];
                    end
                end
                ST_RD_ACK: begin
                    if (master_ack) begin
                        tx <= rd_data;
                        sda_low <= ~rd_data[7];
                        state <= ST_RD;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: ;
            endcase
        end
    end

    // Register writes commit one cycle after the falling edge that ends the byte.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= scl_fall & ~start_det & ~stop_det & (state == ST_WR)
                & (bit_cnt == 4'h8);
            wr_addr <= ptr;
            wr_data <= shift;
        end
    end

    // Open drain: the pin only ever pulls low, enabled active low.
    assign sda_out = 1'b0;
    assign sda_drive_n_out = ~sda_low;

    ////////////////////////////////////////////////////////////////////////////////
    // Shutdown cause flags and summary flag.

    assign cause_set[pmic_regs_pkg::OVERHEAT_BIT] = overheat_shutdown_in;
    assign cause_set[pmic_regs_pkg::RAIL_FAULT_BIT] =
        rail_fault_shutdown_in & ~rail_fault_masked_in;
    assign cause_set[pmic_regs_pkg::UNDERVOLTAGE_BIT] = undervoltage_shutdown_in;
    // No configuration enables this source, so it is never set.
    assign cause_set[pmic_regs_pkg::UNUSED_CAUSE_BIT] = 1'b0;

    generate
        for (genvar i = 0; i < pmic_regs_pkg::CAUSE_WIDTH; i++) begin : g_cause
            assign cause_clr[i] = wr_stb & (wr_addr == pmic_regs_pkg::ADDR_CAUSE)
                & wr_data[i];
            sticky_flag #(
                .RESET_VALUE(pmic_regs_pkg::CAUSE_RESET[i])
            ) u_flag (
                .clk_in(clk_in),
                .srst_in(srst_in),
                .set_in(cause_set[i]),
                .clear_in(cause_clr[i]),
                .flag_out(cause[i])
            );
        end
    endgenerate

    // The summary clear is refused while any cause is still recorded.
    assign summary_clr = wr_stb & (wr_addr == pmic_regs_pkg::ADDR_SUMMARY)
        & wr_data[pmic_regs_pkg::SUMMARY_BIT] & ~(|cause[2:0]);

    sticky_flag #(
        .RESET_VALUE(pmic_regs_pkg::SUMMARY_RESET)
    ) u_summary (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .set_in(|cause[2:0]),
        .clear_in(summary_clr),
        .flag_out(summary)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Rail control bytes; resets are the factory configuration.

    rail_ctrl_reg #(.RESET_VALUE(RAIL1_RESET)) u_rail1 (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .write_in(wr_stb & (wr_addr == pmic_regs_pkg::ADDR_RAIL1)),
        .data_in(wr_data),
        .value_out(rail1)
    );

    rail_ctrl_reg #(.RESET_VALUE(RAIL2_RESET)) u_rail2 (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .write_in(wr_stb & (wr_addr == pmic_regs_pkg::ADDR_RAIL2)),
        .data_in(wr_data),
        .value_out(rail2)
    );

    // Reset packs the rail3 code into bits 7:1 and the passive discharge select into bit 0.
    rail_ctrl_reg #(.RESET_VALUE({RAIL3_CODE_RESET, RAIL3_PASSIVE_RESET})) u_rail3 (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .write_in(wr_stb & (wr_addr == pmic_regs_pkg::ADDR_RAIL3)),
        .data_in(wr_data),
        .value_out(rail3)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux and outputs.

    always_comb begin
        rd_data = pmic_regs_pkg::READ_UNMAPPED;
        unique case (ptr)
            pmic_regs_pkg::ADDR_SUMMARY: rd_data[pmic_regs_pkg::SUMMARY_BIT] = summary;
            pmic_regs_pkg::ADDR_CAUSE: rd_data[3:0] = cause;
            pmic_regs_pkg::ADDR_RAIL1: rd_data = rail1;
            pmic_regs_pkg::ADDR_RAIL2: rd_data = rail2;
            pmic_regs_pkg::ADDR_RAIL3: rd_data = rail3;
            default: rd_data = pmic_regs_pkg::READ_UNMAPPED;
        endcase
    end

    assign shutdown_cause_out = cause;
    assign shutdown_summary_flag_out = summary;
    // Bit 0 low slews the output down actively, high lets it decay.
    assign rail1_control_out = rail1;
    assign rail2_control_out = rail2;
    assign rail3_passive_discharge_out = rail3.passive_discharge;
    assign rail_step_mv_out = STEP_IS_COARSE ? pmic_regs_pkg::STEP_COARSE_MV
        : pmic_regs_pkg::STEP_FINE_MV;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    logic wr_cause;
    assign wr_cause = wr_stb & (wr_addr == pmic_regs_pkg::ADDR_CAUSE);

    property p_cause_reset;
        $past(srst_in) |-> (cause == pmic_regs_pkg::CAUSE_RESET) && !summary;
    endproperty
    a_cause_reset: assert property (p_cause_reset) else $error("cause not clear after reset");

    property p_uv_set;
        undervoltage_shutdown_in |=> cause[2] ##1 summary;
    endproperty
    a_uv_set: assert property (p_uv_set) else $error("undervoltage cause not recorded");

    property p_fault_set;
        rail_fault_shutdown_in && !rail_fault_masked_in |=> cause[1];
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("rail fault cause missed");

    property p_fault_masked;
        $rose(cause[1]) |-> $past(rail_fault_shutdown_in && !rail_fault_masked_in);
    endproperty
    a_fault_masked: assert property (p_fault_masked) else $error("masked fault set cause");

    property p_temp_set;
        overheat_shutdown_in |=> cause[0];
    endproperty
    a_temp_set: assert property (p_temp_set) else $error("overheat cause missed");

    property p_sticky;
        cause[2] && !(wr_cause && wr_data[2]) |=> cause[2];
    endproperty
    a_sticky: assert property (p_sticky) else $error("cause flag dropped without clear");

    property p_w1c;
        wr_cause && wr_data[2] && !undervoltage_shutdown_in |=> !cause[2];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear cause");

    property p_summary;
        (|cause[2:0]) |=> summary;
    endproperty
    a_summary: assert property (p_summary) else $error("summary not set by cause");

    property p_summary_hold;
        summary && (|cause[2:0]) |=> summary;
    endproperty
    a_summary_hold: assert property (p_summary_hold) else $error("summary cleared early");

    property p_unused_zero;
        (state == ST_RD) && (ptr == pmic_regs_pkg::ADDR_CAUSE) |-> rd_data[7:3] == 5'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("cause bits 7:3 not zero");

    property p_rail1_write;
        wr_stb && (wr_addr == pmic_regs_pkg::ADDR_RAIL1) |=> rail1 == $past(wr_data);
    endproperty
    a_rail1_write: assert property (p_rail1_write) else $error("rail1 byte not written");

    property p_rail3_out;
        wr_stb && (wr_addr == pmic_regs_pkg::ADDR_RAIL3)
            |=> rail3_passive_discharge_out == $past(wr_data[0]);
    endproperty
    a_rail3_out: assert property (p_rail3_out) else $error("rail3 discharge not written");

    c_uv: cover property (undervoltage_shutdown_in ##1 cause[2]);
    c_clear: cover property (cause[2] ##1 wr_cause ##1 !cause[2]);
    c_summary_clr: cover property (summary ##1 summary_clr ##1 !summary);
    c_rd: cover property ((state == ST_RD_ACK) && master_ack);

endmodule // shutdown_cause_and_buck_voltage_regs

`default_nettype wire

// File: tb/mgmt_host_model.sv
/*
 * Behavioural host on the two-wire management bus: START, STOP, bytes and register access.
 * Assumes the data line is resolved outside the model with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none

module mgmt_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    // Clock.
    input wire logic clk_in,
    // Bus pins.
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Four cycles per phase keeps each bus clock phase above the three-cycle minimum.
    task automatic gap();
        repeat (4) @(posedge clk_in);
        #1;
    endtask

    task automatic bit_io(input logic b, output logic seen);
        @(posedge clk_in);
        #1;
        sda_out = b;
        gap();
        scl_out = 1'b1;
        gap();
        seen = sda_in;
        scl_out = 1'b0;
    endtask

    task automatic start();
        sda_out = 1'b1;
        gap();
        scl_out = 1'b1;
        gap();
        sda_out = 1'b0;
        gap();
        scl_out = 1'b0;
    endtask

    task automatic stop();
        @(posedge clk_in);
        #1;
        sda_out = 1'b0;
        gap();
        scl_out = 1'b1;
        gap();
        sda_out = 1'b1;
        gap();
    endtask

    task automatic byte_out(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
    endtask

    task automatic byte_in(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // At the cause and summary offsets a set bit in data asks to clear the matching sticky flag; rail bytes store data.
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data);
        write_dev(DEV_ADDR, ptr, data);
    endtask

    // A target that does not own the address must ignore the whole frame.
    task automatic write_dev(input logic [6:0] dev, input logic [7:0] ptr,
        input logic [7:0] data);
        start();
        byte_out({dev, 1'b0});
        byte_out(ptr);
        byte_out(data);
        stop();
    endtask

    // Two bytes in one read; acknowledging the first asks for the next offset.
    task automatic read_two(input logic [7:0] ptr, output logic [7:0] d0,
        output logic [7:0] d1);
        start();
        byte_out({DEV_ADDR, 1'b0});
        byte_out(ptr);
        start();
        byte_out({DEV_ADDR, 1'b1});
        byte_in(1'b0, d0);
        byte_in(1'b1, d1);
        stop();
    endtask

    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data);
        start();
        byte_out({DEV_ADDR, 1'b0});
        byte_out(ptr);
        start();
        byte_out({DEV_ADDR, 1'b1});
        byte_in(1'b1, data);
        stop();
    endtask
endmodule // mgmt_host_model

`default_nettype wire

// File: tb/shutdown_cause_and_buck_voltage_regs_bench.sv
/*
 * Self-checking bench for the shutdown-cause and rail control register bank.
 * Assumes the host model in mgmt_host_model and a pull-up on the data line.
 */
`timescale 1ns/1ps
`default_nettype none

module shutdown_cause_and_buck_voltage_regs_bench;
    localparam logic [6:0] BUS_ADDR = 7'h2A; // Arbitrary bus address.
    localparam logic [7:0] R1_INIT = 8'h74;
    localparam logic [7:0] R2_INIT = 8'h61;
    localparam logic [6:0] R3_CODE = 7'h25;
    localparam logic R3_PASS = 1'b1;
    localparam int CYCLE_LIMIT = 40000;
    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata;} row_t;
    localparam row_t ROWS [7] = '{'{8'h20, 8'hA5, 8'hA5}, '{8'h21, 8'h5A, 8'h5A},
        '{8'h22, 8'hFE, 8'hFE}, '{8'h22, 8'h01, 8'h01}, '{8'h05, 8'hFF, 8'h00},
        '{8'h40, 8'h3C, 8'h00}, '{8'h02, 8'h77, 8'h00}};

    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic uv, fault, masked, heat;
    wire logic scl, host_sda, sda_line;
    logic dev_sda, dev_drive_n, summary, rail3_pass;
    logic [3:0] cause;
    logic [4:0] step_mv;
    logic [7:0] rd0, rd1;
    pmic_regs_pkg::rail_ctrl_t rail1, rail2;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;

    // The device only pulls low; a released line rises through the pull-up.
    assign sda_line = host_sda & (dev_drive_n | dev_sda);

    always #2.5 clk_in = ~clk_in;

    shutdown_cause_and_buck_voltage_regs #(.TARGET_ADDR(BUS_ADDR), .STEP_IS_COARSE(1'b1),
        .RAIL1_RESET(R1_INIT), .RAIL2_RESET(R2_INIT), .RAIL3_CODE_RESET(R3_CODE),
        .RAIL3_PASSIVE_RESET(R3_PASS)) dut_u (
        .clk_in(clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(dev_sda), .sda_drive_n_out(dev_drive_n),
        .undervoltage_shutdown_in(uv), .rail_fault_shutdown_in(fault),
        .rail_fault_masked_in(masked), .overheat_shutdown_in(heat),
        .shutdown_cause_out(cause), .shutdown_summary_flag_out(summary),
        .rail1_control_out(rail1), .rail2_control_out(rail2),
        .rail3_passive_discharge_out(rail3_pass), .rail_step_mv_out(step_mv));

    mgmt_host_model #(.DEV_ADDR(BUS_ADDR)) host_u (
        .clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_out(host_sda));

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] v;
        host_u.read_reg(ptr, v);
        check(v, exp);
    endtask

    // One-cycle event pulse: 0 overheat, 1 rail fault, 2 undervoltage.
    task automatic fire(input int which);
        @(posedge clk_in);
        #1;
        uv = (which == 2);
        fault = (which == 1);
        heat = (which == 0);
        @(posedge clk_in);
        #1;
        {uv, fault, heat} = 3'b000;
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            n_mismatch++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        {uv, fault, masked, heat} = 4'h0;
        repeat (12) @(posedge clk_in);
        #1;
        srst_in = 1'b0;
        check({4'h0, cause}, 8'h00);
        check({3'h0, step_mv}, 8'h19);
        rd_check(8'h05, 8'h00);
        rd_check(8'h20, R1_INIT);
        rd_check(8'h21, R2_INIT);
        rd_check(8'h22, {R3_CODE, R3_PASS});
        foreach (ROWS[i]) begin
            host_u.write_reg(ROWS[i].addr, ROWS[i].wdata);
            rd_check(ROWS[i].addr, ROWS[i].rdata);
        end
        check({1'b0, rail1.voltage_code}, 8'h52);
        check({7'h00, rail1.passive_discharge}, 8'h01);
        check(rail2, 8'h5A);
        check({7'h00, rail3_pass}, 8'h01);
        // A two-byte read walks the pointer from rail1 on to rail2.
        host_u.read_two(8'h20, rd0, rd1);
        check(rd0, 8'hA5);
        check(rd1, 8'h5A);
        // A frame for another bus address must leave the registers alone.
        host_u.write_dev(BUS_ADDR ^ 7'h01, 8'h21, 8'h00);
        rd_check(8'h21, 8'h5A);
        // A masked fault must leave every flag alone.
        masked = 1'b1;
        fire(1);
        masked = 1'b0;
        check({3'h0, summary, cause}, 8'h00);
        for (int b = 0; b < 3; b++) begin
            fire(b);
            check({4'h0, cause}, 8'h01 << b);
            check({7'h00, summary}, 8'h01);
            host_u.write_reg(8'h02, 8'h08);
            rd_check(8'h02, 8'h08);
            host_u.write_reg(8'h05, ~(8'h01 << b));
            rd_check(8'h05, 8'h01 << b);
            host_u.write_reg(8'h05, 8'h01 << b);
            rd_check(8'h05, 8'h00);
            host_u.write_reg(8'h02, 8'h08);
            rd_check(8'h02, 8'h00);
        end
        // A second reset in mid-run must restore the factory bytes too.
        fire(0);
        host_u.write_reg(8'h20, 8'h00);
        host_u.write_reg(8'h22, 8'h00);
        srst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        srst_in = 1'b0;
        check({3'h0, summary, cause}, 8'h00);
        check(rail1, R1_INIT);
        check({7'h00, rail3_pass}, {7'h00, R3_PASS});
        rd_check(8'h22, {R3_CODE, R3_PASS});
        wrap_up();
    end
endmodule // shutdown_cause_and_buck_voltage_regs_bench

`default_nettype wire
